/* logic/pmbus_telemetry_status_bank.sv */
// Telemetry, trim and status register bank behind a PMBus slave port.
// Assumes a same-clock sample source and asynchronous fault levels.
//
// Summary of operation
// [RULE1] Output voltage reading is a 16-bit mantissa, exponent -10.
// [RULE2] Output offset trim: 16-bit signed, exponent -10, -125 to 124 mV.
// [RULE3] Both gain trims: exponent -8, 11-bit mantissa, -0.125 to 0.121.
// [RULE4] Corrected reading = raw times (1 + gain) plus offset.
// [RULE5] Input reading: exponent -5 in high bits, mantissa top bit zero.
// [RULE6] Input offset trim: exponent -5, signed mantissa, -2 to 1.968 V.
// [RULE7] A one in any status bit flags the condition.
// [RULE8] Summary byte: off, OV, OC, input UV, temp, comm, other.
// [RULE9] Status word repeats summary; high byte vout, iout, not-good.
// [RULE10] Output voltage status: OV fault bit 7, UV fault bit 4.
// [RULE11] Output current status: OC fault bit 7, OC warning bit 5.
// [RULE12] Temperature status: fault bit 7, warning bit 6.
// [RULE13] Comm status: bad command 7/6, PEC fail 5, other 1.
// [RULE14] Input floor constant: exponent -2, mantissa 12, read-only.
// [RULE15] Output floor constant: exponent -10, mantissa 614, read-only.
// [RULE16] Identity word: type, tail 10; revision, tail 000.
// [RULE17] Clear-faults command clears all fault bits and the alert.
// [RULE18] Readings refresh every 200 us with a 16-sample average.
// [RULE19] Reject turn-on below turn-off; flag comm and data, alert.
// [RULE20] Fault bits stay latched until cleared or reset.
`timescale 1ns/1ps
`include "pmbus_telemetry_regs.svh"
`default_nettype none
module pmbus_telemetry_status_bank #(
  parameter logic [6:0] SLAVE_ADDR = 7'h40,
  parameter logic [5:0] MODULE_TYPE = 6'h15, // Arbitrary value
  parameter logic [4:0] MODULE_REV = 5'h01, // Arbitrary value
  parameter int REFRESH_CYCLES = `REFRESH_TIME_US * `CLK_FREQ_MHZ
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Serial management link
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic alert_o,
  output logic alert_oe_o,
  // Measurement samples
  input wire logic sample_valid_i,
  input wire logic [15:0] sample_vout_i,
  input wire logic [9:0] sample_vin_i,
  // Protection conditions
  input wire pmbus_telemetry_pkg::fault_t faults_i,
  input wire logic output_in_regulation_i
);
  logic [1:0] scl_sync, sda_sync;
  logic scl_d, sda_d, pg_meta, pg_sync;
  pmbus_telemetry_pkg::fault_t flt_meta, flt_sync, flt_reg, flt_next;
  pmbus_telemetry_pkg::link_or_storage_fault_t link_reg, link_next, link_evt;
  pmbus_telemetry_pkg::link_state_t st_reg;
  logic scl_hi, sda_hi, scl_rise, scl_fall, start_det, stop_det;
  logic [31:0] win_cnt;
  logic [4:0] smp_cnt;
  logic [19:0] acc_vout;
  logic [13:0] acc_vin;
  logic [15:0] raw_vout, vout_rd_reg, vin_rd_reg;
  logic [9:0] raw_vin;
  logic publish;
  logic [15:0] vout_ofs_reg, vout_gain_reg, vin_ofs_reg, vin_gain_reg;
  logic [10:0] vin_on_reg, vin_off_reg;
  logic [3:0] bit_cnt;
  logic [7:0] shift_reg, tx_byte, cmd_reg, crc_reg, tx_next;
  logic [2:0] byte_idx, rd_idx, data_cnt;
  logic addr_phase, is_read;
  logic [15:0] wdata, rd_word;
  logic [1:0] rlen, wlen;
  logic addr_done, addr_hit, wr_end, len_ok, pec_ok, do_write;
  logic clear_req, vin_reject;
  logic [7:0] status_lo, status_hi;

  function automatic logic [15:0] clamp(input logic [15:0] v,
      input logic [15:0] lo, input logic [15:0] hi);
    if ($signed(v) < $signed(lo)) clamp = lo;
    else if ($signed(v) > $signed(hi)) clamp = hi;
    else clamp = v;
  endfunction

  function automatic logic [15:0] correct(input logic [15:0] raw,
      input logic [15:0] gain, input logic [15:0] ofs,
      input logic [15:0] top);
    logic signed [33:0] prod;
    logic signed [33:0] sum;
    prod = $signed({18'h0, raw}) * $signed({{18{gain[15]}}, gain});
    sum = $signed({18'h0, raw}) + (prod >>> `GAIN_FRAC_BITS)
        + $signed({{18{ofs[15]}}, ofs});
    if (sum < 0) correct = '0;
    else if (sum > $signed({18'h0, top})) correct = top;
    else correct = sum[15:0];
  endfunction

  function automatic logic [7:0] crc8(input logic [7:0] c,
      input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++) begin
      x = x[7] ? ((x << 1) ^ `PEC_POLY) : (x << 1);
    end
    crc8 = x;
  endfunction

  // Upper pair: read length, lower pair: write length
  function automatic logic [3:0] cmd_info(input logic [7:0] c);
    case (c)
      `CMD_CLEAR_FAULTS: cmd_info = {`LEN_NONE, `LEN_NONE};
      `CMD_VIN_ON, `CMD_VIN_OFF, `CMD_VOUT_OFS_TRIM, `CMD_VOUT_GAIN_TRIM,
      `CMD_VIN_OFS_TRIM, `CMD_VIN_GAIN_TRIM:
        cmd_info = {`LEN_WORD, `LEN_WORD};
      `CMD_SUMMARY_OCTET, `CMD_VOUT_FAULTS, `CMD_IOUT_FAULTS,
      `CMD_THERMAL_FAULTS, `CMD_LINK_FAULTS:
        cmd_info = {`LEN_BYTE, `LEN_NO_WRITE};
      `CMD_SUMMARY_DOUBLE, `CMD_VIN_READING, `CMD_VOUT_READING,
      `CMD_VIN_FLOOR, `CMD_VOUT_FLOOR, `CMD_IDENTITY:
        cmd_info = {`LEN_WORD, `LEN_NO_WRITE};
      default: cmd_info = {`LEN_NONE, `LEN_NO_WRITE};
    endcase
  endfunction

  // Two stages on every asynchronous input before use
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      flt_meta <= '0;
      flt_sync <= '0;
      pg_meta <= 1'b1;
      pg_sync <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_i};
      sda_sync <= {sda_sync[0], sda_i};
      scl_d <= scl_sync[1];
      sda_d <= sda_sync[1];
      flt_meta <= faults_i;
      flt_sync <= flt_meta;
      pg_meta <= output_in_regulation_i;
      pg_sync <= pg_meta;
    end
  end

  assign scl_hi = scl_sync[1];
  assign sda_hi = sda_sync[1];
  assign scl_rise = scl_hi && !scl_d;
  assign scl_fall = !scl_hi && scl_d;
  assign start_det = scl_hi && scl_d && sda_d && !sda_hi;
  assign stop_det = scl_hi && scl_d && !sda_d && sda_hi;

  // Extra samples in a window are dropped rather than skewing the mean
  assign publish = (win_cnt == 32'(REFRESH_CYCLES - 1));
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      win_cnt <= '0;
      smp_cnt <= '0;
      acc_vout <= '0;
      acc_vin <= '0;
      raw_vout <= '0;
      raw_vin <= '0;
    end else if (publish) begin
      win_cnt <= '0;
      smp_cnt <= '0;
      acc_vout <= '0;
      acc_vin <= '0;
      if (smp_cnt == `AVG_SAMPLES) begin
        raw_vout <= acc_vout[`AVG_SHIFT +: 16]; // see [RULE18]
        raw_vin <= acc_vin[`AVG_SHIFT +: 10];
      end
    end else begin
      win_cnt <= win_cnt + 32'h1;
      if (sample_valid_i && smp_cnt != `AVG_SAMPLES) begin
        acc_vout <= acc_vout + {4'h0, sample_vout_i}; // see [RULE18]
        acc_vin <= acc_vin + {4'h0, sample_vin_i};
        smp_cnt <= smp_cnt + 5'h1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vout_rd_reg <= '0;
      vin_rd_reg <= '0;
    end else begin
      // see [RULE4]
      vout_rd_reg <= correct(raw_vout, vout_gain_reg, vout_ofs_reg,
                             `VOUT_MANT_MAX);
      vin_rd_reg <= correct({6'h0, raw_vin}, vin_gain_reg, vin_ofs_reg,
                            `VIN_MANT_MAX);
    end
  end

  assign {rlen, wlen} = cmd_info(cmd_reg);
  assign addr_done = st_reg == pmbus_telemetry_pkg::LINK_RX && scl_fall
      && bit_cnt == `BYTE_BITS && addr_phase;
  assign addr_hit = addr_done && shift_reg[7:1] == SLAVE_ADDR;
  assign data_cnt = byte_idx - 3'h1;
  assign wr_end = stop_det && st_reg == pmbus_telemetry_pkg::LINK_RX
      && !is_read && byte_idx != 3'h0;
  assign len_ok = wlen != `LEN_NO_WRITE && data_cnt == {1'b0, wlen};
  assign pec_ok = wlen != `LEN_NO_WRITE
      && data_cnt == {1'b0, wlen} + 3'h1;
  assign do_write = wr_end && (len_ok || (pec_ok && crc_reg == 8'h00));
  assign clear_req = do_write && cmd_reg == `CMD_CLEAR_FAULTS;
  assign vin_reject = do_write // see [RULE19]
      && ((cmd_reg == `CMD_VIN_ON && wdata[10:0] < vin_off_reg)
      || (cmd_reg == `CMD_VIN_OFF && wdata[10:0] > vin_on_reg));

  always_comb begin
    link_evt.bad_cmd = (wr_end && wlen == `LEN_NO_WRITE
        && (rlen == `LEN_NONE || data_cnt != 3'h0))
        || (addr_hit && shift_reg[0] && rlen == `LEN_NONE);
    link_evt.bad_data = vin_reject; // see [RULE19]
    link_evt.pec_fail = wr_end && pec_ok && crc_reg != 8'h00;
    link_evt.other = wr_end && wlen != `LEN_NO_WRITE && !len_ok && !pec_ok;
  end

  // Serial slave: byte framing, acknowledge, read-out with PEC byte
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= pmbus_telemetry_pkg::LINK_IDLE;
      bit_cnt <= '0;
      shift_reg <= '0;
      tx_byte <= '0;
      cmd_reg <= '0;
      crc_reg <= '0;
      byte_idx <= '0;
      rd_idx <= '0;
      addr_phase <= 1'b0;
      is_read <= 1'b0;
      wdata <= '0;
      sda_oe_o <= 1'b0;
      sda_o <= 1'b0;
    end else if (start_det) begin
      st_reg <= pmbus_telemetry_pkg::LINK_RX;
      bit_cnt <= '0;
      addr_phase <= 1'b1;
      sda_oe_o <= 1'b0;
      if (st_reg == pmbus_telemetry_pkg::LINK_IDLE) begin
        crc_reg <= '0;
        byte_idx <= '0;
      end
    end else if (stop_det) begin
      st_reg <= pmbus_telemetry_pkg::LINK_IDLE;
      sda_oe_o <= 1'b0;
    end else begin
      unique case (st_reg)
        pmbus_telemetry_pkg::LINK_IDLE: begin
        end
        pmbus_telemetry_pkg::LINK_RX: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_hi};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == `BYTE_BITS) begin
            bit_cnt <= '0;
            crc_reg <= crc8(crc_reg, shift_reg);
            if (addr_phase) begin
              addr_phase <= 1'b0;
              if (addr_hit) begin
                st_reg <= pmbus_telemetry_pkg::LINK_ACK;
                sda_oe_o <= 1'b1;
                is_read <= shift_reg[0];
                rd_idx <= '0;
              end else begin
                st_reg <= pmbus_telemetry_pkg::LINK_IDLE;
              end
            end else begin
              st_reg <= pmbus_telemetry_pkg::LINK_ACK;
              sda_oe_o <= 1'b1;
              if (byte_idx == 3'h0) cmd_reg <= shift_reg;
              if (byte_idx == 3'h1) wdata[7:0] <= shift_reg;
              if (byte_idx == 3'h2) wdata[15:8] <= shift_reg;
              if (byte_idx != 3'h7) byte_idx <= byte_idx + 3'h1;
            end
          end
        end
        pmbus_telemetry_pkg::LINK_ACK, pmbus_telemetry_pkg::LINK_MACK: begin
          if (st_reg == pmbus_telemetry_pkg::LINK_MACK && scl_rise
              && sda_hi) begin
            st_reg <= pmbus_telemetry_pkg::LINK_IDLE;
          end else if (scl_fall) begin
            bit_cnt <= '0;
            if (is_read) begin
              st_reg <= pmbus_telemetry_pkg::LINK_TX;
              shift_reg <= tx_next;
              tx_byte <= tx_next;
              sda_oe_o <= !tx_next[7];
            end else begin
              st_reg <= pmbus_telemetry_pkg::LINK_RX;
              sda_oe_o <= 1'b0;
            end
          end
        end
        pmbus_telemetry_pkg::LINK_TX: begin
          if (scl_fall) begin
            if (bit_cnt == `BYTE_BITS - 4'h1) begin
              st_reg <= pmbus_telemetry_pkg::LINK_MACK;
              sda_oe_o <= 1'b0;
              crc_reg <= crc8(crc_reg, tx_byte);
              if (rd_idx != 3'h7) rd_idx <= rd_idx + 3'h1;
            end else begin
              shift_reg <= shift_reg << 1;
              sda_oe_o <= !shift_reg[6];
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
      endcase
    end
  end

  // Writable trims and lockout thresholds
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vout_ofs_reg <= '0;
      vout_gain_reg <= '0;
      vin_ofs_reg <= '0;
      vin_gain_reg <= '0;
      vin_on_reg <= `VIN_ON_DEFAULT;
      vin_off_reg <= `VIN_OFF_DEFAULT;
    end else if (do_write && !vin_reject) begin
      case (cmd_reg)
        `CMD_VOUT_OFS_TRIM: // see [RULE2]
          vout_ofs_reg <= clamp(wdata, `VOUT_OFS_MIN, `VOUT_OFS_MAX);
        `CMD_VOUT_GAIN_TRIM: // see [RULE3]
          vout_gain_reg <= clamp({{5{wdata[10]}}, wdata[10:0]},
                                 `GAIN_MIN, `GAIN_MAX);
        `CMD_VIN_OFS_TRIM: // see [RULE6]
          vin_ofs_reg <= clamp({{5{wdata[10]}}, wdata[10:0]},
                               `VIN_OFS_MIN, `VIN_OFS_MAX);
        `CMD_VIN_GAIN_TRIM: // see [RULE3]
          vin_gain_reg <= clamp({{5{wdata[10]}}, wdata[10:0]},
                                `GAIN_MIN, `GAIN_MAX);
        `CMD_VIN_ON: vin_on_reg <= wdata[10:0];
        `CMD_VIN_OFF: vin_off_reg <= wdata[10:0];
        default: begin
        end
      endcase
    end
  end

  // New events win over a clear in the same cycle
  always_comb begin
    flt_next = (flt_reg & ~{$bits(flt_reg){clear_req}}) // see [RULE20]
        | flt_sync;
    link_next = (link_reg & ~{$bits(link_reg){clear_req}}) | link_evt;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flt_reg <= '0;
      link_reg <= '0;
      alert_oe_o <= 1'b0;
      alert_o <= 1'b0;
    end else begin
      flt_reg <= flt_next; // see [RULE17]
      link_reg <= link_next;
      alert_oe_o <= (|flt_next) || (|link_next); // see [RULE17]
      alert_o <= 1'b0;
    end
  end

  // see [RULE7]
  assign status_lo = {1'b0, flt_reg.output_off, flt_reg.vout_over,
      flt_reg.iout_over, flt_reg.vin_under, // see [RULE8]
      flt_reg.overheat || flt_reg.overheat_warn, |link_reg,
      flt_reg.vout_under || flt_reg.iout_warn};
  assign status_hi = {flt_reg.vout_over || flt_reg.vout_under,
      flt_reg.iout_over || flt_reg.iout_warn, 2'h0, !pg_sync, 3'h0};

  always_comb begin
    case (cmd_reg)
      `CMD_SUMMARY_OCTET: rd_word = {8'h00, status_lo};
      `CMD_SUMMARY_DOUBLE: rd_word = {status_hi, status_lo}; // see [RULE9]
      `CMD_VOUT_FAULTS: // see [RULE10]
        rd_word = {8'h00, flt_reg.vout_over, 2'h0, flt_reg.vout_under, 4'h0};
      `CMD_IOUT_FAULTS: // see [RULE11]
        rd_word = {8'h00, flt_reg.iout_over, 1'b0, flt_reg.iout_warn, 5'h00};
      `CMD_THERMAL_FAULTS: // see [RULE12]
        rd_word = {8'h00, flt_reg.overheat, flt_reg.overheat_warn, 6'h00};
      `CMD_LINK_FAULTS: // see [RULE13]
        rd_word = {8'h00, link_reg.bad_cmd, link_reg.bad_data,
                   link_reg.pec_fail, 3'h0, link_reg.other, 1'b0};
      `CMD_VOUT_READING: rd_word = vout_rd_reg; // see [RULE1]
      `CMD_VIN_READING: // see [RULE5]
        rd_word = {`EXP_M5, 1'b0, vin_rd_reg[9:0]};
      `CMD_VOUT_OFS_TRIM: rd_word = vout_ofs_reg;
      `CMD_VOUT_GAIN_TRIM: rd_word = {`EXP_M8, vout_gain_reg[10:0]};
      `CMD_VIN_OFS_TRIM: rd_word = {`EXP_M5, vin_ofs_reg[10:0]};
      `CMD_VIN_GAIN_TRIM: rd_word = {`EXP_M8, vin_gain_reg[10:0]};
      `CMD_VIN_ON: rd_word = {`EXP_M2, vin_on_reg};
      `CMD_VIN_OFF: rd_word = {`EXP_M2, vin_off_reg};
      `CMD_VIN_FLOOR: rd_word = {`EXP_M2, `VIN_FLOOR_MANT}; // see [RULE14]
      `CMD_VOUT_FLOOR: // see [RULE15]
        rd_word = {`EXP_M10, `VOUT_FLOOR_MANT};
      `CMD_IDENTITY: // see [RULE16]
        rd_word = {MODULE_REV, `ID_HIGH_TAIL, MODULE_TYPE, `ID_LOW_TAIL};
      default: rd_word = 16'hFFFF;
    endcase
    if (rd_idx < {1'b0, rlen}) begin
      tx_next = (rd_idx == 3'h0) ? rd_word[7:0] : rd_word[15:8];
    end else if (rd_idx == {1'b0, rlen}) begin
      tx_next = crc_reg;
    end else begin
      tx_next = 8'hFF;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence reject_seen;
    vin_reject;
  endsequence
  sequence flag_then_keep;
    ##1 (link_reg.bad_data && status_lo[1] && alert_oe_o)
    ##1 (vin_on_reg == $past(vin_on_reg, 2));
  endsequence
  sequence clean_clear;
    clear_req && flt_sync == '0 && link_evt == '0;
  endsequence

  gain_range_a: assert property ( // see [RULE3]
    $signed(vout_gain_reg) >= -32 && $signed(vout_gain_reg) <= 31
    && $signed(vin_gain_reg) >= -32 && $signed(vin_gain_reg) <= 31)
    else $error("gain trim out of range");
  vout_offset_range_a: assert property ( // see [RULE2]
    $signed(vout_ofs_reg) >= -128 && $signed(vout_ofs_reg) <= 127)
    else $error("output offset trim out of range");
  vin_offset_range_a: assert property ( // see [RULE6]
    $signed(vin_ofs_reg) >= -64 && $signed(vin_ofs_reg) <= 63)
    else $error("input offset trim out of range");
  fault_set_a: assert property ( // see [RULE7]
    $rose(flt_sync.vout_over) |=> status_lo[5] && alert_oe_o)
    else $error("overvoltage not flagged");
  fault_latch_a: assert property ( // see [RULE20]
    flt_reg.overheat && !clear_req |=> flt_reg.overheat)
    else $error("latched fault dropped without clear");
  clear_all_a: assert property ( // see [RULE17]
    clean_clear |=> flt_reg == '0 && link_reg == '0 && !alert_oe_o)
    else $error("clear did not empty status");
  reject_flags_a: assert property ( // see [RULE19]
    reject_seen |-> flag_then_keep)
    else $error("rejected threshold write mishandled");
  vin_order_a: assert property ( // see [RULE19]
    vin_on_reg >= vin_off_reg)
    else $error("turn-on threshold below turn-off");
  avg_publish_a: assert property ( // see [RULE18]
    publish && smp_cnt == `AVG_SAMPLES
    |=> raw_vout == $past(acc_vout[19:4]) && win_cnt == 32'h0)
    else $error("average not published");
endmodule
`default_nettype wire

/* inc/pmbus_telemetry_regs.svh */
// Constants for the telemetry and status register bank.
// Assumes a 100 MHz core clock and PMBus linear data formats.
`default_nettype none
`ifndef PMBUS_TELEMETRY_REGS_SVH
`define PMBUS_TELEMETRY_REGS_SVH
// Command codes
`define CMD_CLEAR_FAULTS 8'h03
`define CMD_VIN_ON 8'h35
`define CMD_VIN_OFF 8'h36
`define CMD_SUMMARY_OCTET 8'h78
`define CMD_SUMMARY_DOUBLE 8'h79
`define CMD_VOUT_FAULTS 8'h7A
`define CMD_IOUT_FAULTS 8'h7B
`define CMD_THERMAL_FAULTS 8'h7D
`define CMD_LINK_FAULTS 8'h7E
`define CMD_VIN_READING 8'h88
`define CMD_VOUT_READING 8'h8B
`define CMD_VIN_FLOOR 8'hA0
`define CMD_VOUT_FLOOR 8'hA4
`define CMD_IDENTITY 8'hD0
`define CMD_VOUT_OFS_TRIM 8'hD4
`define CMD_VOUT_GAIN_TRIM 8'hD5
`define CMD_VIN_OFS_TRIM 8'hD6
`define CMD_VIN_GAIN_TRIM 8'hD7
// Transfer lengths in data bytes
`define LEN_NONE 2'h0
`define LEN_BYTE 2'h1
`define LEN_WORD 2'h2
`define LEN_NO_WRITE 2'h3
// Linear format exponents and fixed values
`define EXP_M10 5'h16
`define EXP_M8 5'h18
`define EXP_M5 5'h1B
`define EXP_M2 5'h1E
`define VIN_FLOOR_MANT 11'h00C
`define VOUT_FLOOR_MANT 11'h266
`define ID_LOW_TAIL 2'h2
`define ID_HIGH_TAIL 3'h0
// Trim limits as sign-extended mantissas
`define VOUT_OFS_MIN 16'hFF80
`define VOUT_OFS_MAX 16'h007F
`define GAIN_MIN 16'hFFE0
`define GAIN_MAX 16'h001F
`define VIN_OFS_MIN 16'hFFC0
`define VIN_OFS_MAX 16'h003F
`define VIN_MANT_MAX 16'h03FF
`define VOUT_MANT_MAX 16'hFFFF
`define GAIN_FRAC_BITS 8
// Input lockout threshold defaults (mantissa, exponent -2)
`define VIN_ON_DEFAULT 11'h00B
`define VIN_OFF_DEFAULT 11'h00A
// Averaging and timing
`define REFRESH_TIME_US 200
`define CLK_FREQ_MHZ 100
`define AVG_SAMPLES 5'h10
`define AVG_SHIFT 4
// Serial link framing
`define BYTE_BITS 4'h8
`define PEC_POLY 8'h07
`endif
`default_nettype wire

/* inc/pmbus_telemetry_pkg.sv */
// Types shared by the telemetry and status register bank.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package pmbus_telemetry_pkg;
  typedef struct packed {
    logic output_off;
    logic vout_over;
    logic vout_under;
    logic iout_over;
    logic iout_warn;
    logic vin_under;
    logic overheat;
    logic overheat_warn;
  } fault_t;
  typedef struct packed {
    logic bad_cmd;
    logic bad_data;
    logic pec_fail;
    logic other;
  } link_or_storage_fault_t;
  typedef enum logic [2:0] {
    LINK_IDLE,
    LINK_RX,
    LINK_ACK,
    LINK_TX,
    LINK_MACK
  } link_state_t;
endpackage
`default_nettype wire

/* verification/pmbus_host_model.sv */
// Host model: bit-level PMBus master for byte and word transfers.
// Assumes the bench resolves the open-drain wire into sda_w_i.
`timescale 1ns/1ps
`default_nettype none
module pmbus_host_model (
  // Clock and resolved wire
  input wire logic clk_i,
  input wire logic sda_w_i,
  // Host drives, clock stands high between frames
  output logic scl_o,
  output logic sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic start();
    sda_low_o = 1'b0;
    tk(4);
    scl_o = 1'b1;
    tk(4);
    sda_low_o = 1'b1;
    tk(4);
    scl_o = 1'b0;
    tk(4);
  endtask
  task automatic stop();
    sda_low_o = 1'b1;
    tk(4);
    scl_o = 1'b1;
    tk(4);
    sda_low_o = 1'b0;
    tk(4);
  endtask
  // Quarter bit of 4 clocks gives the 160 ns link period
  task automatic bit_io(input logic b, output logic r);
    sda_low_o = !b;
    tk(4);
    scl_o = 1'b1;
    tk(4);
    r = sda_w_i;
    tk(4);
    scl_o = 1'b0;
    tk(4);
  endtask
  task automatic xfer(input logic [7:0] d, input logic n9,
      output logic [7:0] q);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(n9, r);
  endtask
  // Low byte first; the device commits only at the stop
  task automatic wr(input logic [7:0] c, input int n,
      input logic [15:0] d);
    logic [7:0] q;
    start();
    xfer(8'h80, 1'b1, q);
    xfer(c, 1'b1, q);
    for (int i = 0; i < n; i++) xfer(d[8*i +: 8], 1'b1, q);
    stop();
  endtask
  // Last data byte is refused, so no checksum byte follows
  task automatic rd(input logic [7:0] c, input int n,
      output logic [15:0] d);
    logic [7:0] q;
    d = 16'h0000;
    start();
    xfer(8'h80, 1'b1, q);
    xfer(c, 1'b1, q);
    start();
    xfer(8'h81, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      xfer(8'hFF, i == n - 1, q);
      d[8*i +: 8] = q;
    end
    stop();
  endtask
endmodule
`default_nettype wire

/* verification/pmbus_telemetry_status_bank_tb.sv */
// Self-checking bench for the telemetry and status register bank.
// Assumes the host model is compiled before this file.
`timescale 1ns/1ps
`include "pmbus_telemetry_regs.svh"
`default_nettype none
module pmbus_telemetry_status_bank_tb;
  logic clk_i, rst_n_i, scl, host_low, sda_o, sda_oe_o, alert_o;
  logic alert_oe_o, sample_valid_i, output_in_regulation_i;
  logic [15:0] sample_vout_i, rd_d, x, e;
  logic [9:0] sample_vin_i;
  pmbus_telemetry_pkg::fault_t faults_i, ff;
  wire logic sda_w = !(sda_oe_o || host_low);
  int n_fail = 0;
  int samples_checked = 0;
  int seed = 837;
  int g, o, oi;
  logic [7:0] st_cmd [6] = '{`CMD_SUMMARY_OCTET, `CMD_SUMMARY_DOUBLE,
    `CMD_VOUT_FAULTS, `CMD_IOUT_FAULTS, `CMD_THERMAL_FAULTS,
    `CMD_LINK_FAULTS};
  pmbus_telemetry_status_bank #(.MODULE_TYPE(6'h2A), .MODULE_REV(5'h13),
    .REFRESH_CYCLES(40)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .alert_o(alert_o), .alert_oe_o(alert_oe_o),
    .sample_valid_i(sample_valid_i), .sample_vout_i(sample_vout_i),
    .sample_vin_i(sample_vin_i), .faults_i(faults_i),
    .output_in_regulation_i(output_in_regulation_i));
  pmbus_host_model host (.clk_i(clk_i), .sda_w_i(sda_w), .scl_o(scl),
    .sda_low_o(host_low));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic check(input string nm, input logic [15:0] s,
      input logic [15:0] t);
    samples_checked++;
    if (s !== t) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, t, s);
    end
  endtask
  task automatic rdc(input string nm, input logic [7:0] c, input int n,
      input logic [15:0] t);
    host.rd(c, n, rd_d);
    check(nm, rd_d, t);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [15:0] word_of(
      pmbus_telemetry_pkg::fault_t f, logic pg);
    return {f.vout_over | f.vout_under, f.iout_over | f.iout_warn, 2'h0,
      !pg, 4'h0, f.output_off, f.vout_over, f.iout_over, f.vin_under,
      f.overheat | f.overheat_warn, 1'b0, f.vout_under | f.iout_warn};
  endfunction
  // Raw values are multiples of 256, so the gain product is exact
  function automatic int corr(int raw, int gn, int ofs);
    return raw + raw * gn / 256 + ofs;
  endfunction
  initial begin
    #700_000;
    n_fail++;
    finish_test();
  end
  initial begin
    {rst_n_i, sample_valid_i, sample_vout_i, sample_vin_i} = '0;
    faults_i = '0;
    output_in_regulation_i = 1'b1;
    repeat (3) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (6) @(negedge clk_i);
    rdc("ident", `CMD_IDENTITY, 2,
      {5'h13, 3'h0, 6'h2A, 2'h2});
    rdc("vin_floor", `CMD_VIN_FLOOR, 2, 16'hF00C);
    rdc("vout_floor", `CMD_VOUT_FLOOR, 2, 16'hB266);
    foreach (st_cmd[i])
      rdc("st_rst", st_cmd[i], 2 - int'(i != 1), 16'h0);
    host.wr(`CMD_VOUT_OFS_TRIM, 2, 16'h1234);
    rdc("ofs_clamp", `CMD_VOUT_OFS_TRIM, 2, 16'h007F);
    o = $random(seed) % 125;
    g = $random(seed) % 32;
    oi = $random(seed) % 64;
    e = 16'($random(seed)) & 16'h00FF;
    host.wr(`CMD_VOUT_OFS_TRIM, 2, o[15:0]);
    host.wr(`CMD_VOUT_GAIN_TRIM, 2, {5'h00, g[10:0]});
    host.wr(`CMD_VIN_GAIN_TRIM, 2, {5'h00, g[10:0]});
    host.wr(`CMD_VIN_OFS_TRIM, 2, {5'h1B, oi[10:0]});
    rdc("vout_ofs", `CMD_VOUT_OFS_TRIM, 2, o[15:0]);
    rdc("vout_gain", `CMD_VOUT_GAIN_TRIM, 2, {5'h18, g[10:0]});
    rdc("vin_gain", `CMD_VIN_GAIN_TRIM, 2, {5'h18, g[10:0]});
    rdc("vin_ofs", `CMD_VIN_OFS_TRIM, 2, {5'h1B, oi[10:0]});
    // Alternating spread keeps any 16 consecutive samples centred
    for (int i = 0; i < 130; i++) begin
      sample_valid_i = 1'b1;
      sample_vout_i = i[0] ? 16'h4000 + e : 16'h4000 - e;
      sample_vin_i = i[0] ? 10'h200 + e[9:0] : 10'h200 - e[9:0];
      @(negedge clk_i);
    end
    sample_valid_i = 1'b0;
    repeat (90) @(negedge clk_i);
    x = 16'(corr(16'h4000, g, o));
    rdc("vout_rd", `CMD_VOUT_READING, 2, x);
    x = 16'(corr(10'h200, g, oi));
    rdc("vin_rd", `CMD_VIN_READING, 2,
      {6'h36, x[9:0]});
    for (int b = 0; b < 8; b++) begin
      faults_i = pmbus_telemetry_pkg::fault_t'(8'h80 >> b);
      output_in_regulation_i = 1'($random(seed));
      repeat (8) @(negedge clk_i);
      check("alert_set", 16'(alert_oe_o), 16'h1);
      ff = faults_i;
      faults_i = '0;
      repeat (8) @(negedge clk_i);
      rdc("word", `CMD_SUMMARY_DOUBLE, 2,
        word_of(ff, output_in_regulation_i));
      rdc("vout_st", `CMD_VOUT_FAULTS, 1,
        {8'h0, ff.vout_over, 2'h0, ff.vout_under, 4'h0});
      rdc("iout_st", `CMD_IOUT_FAULTS, 1,
        {8'h0, ff.iout_over, 1'b0, ff.iout_warn, 5'h0});
      rdc("temp_st", `CMD_THERMAL_FAULTS, 1,
        {8'h0, ff.overheat, ff.overheat_warn, 6'h0});
      output_in_regulation_i = 1'b1;
      host.wr(`CMD_CLEAR_FAULTS, 0, 16'h0000);
      repeat (4) @(negedge clk_i);
      check("alert_clr", 16'(alert_oe_o), 16'h0);
      rdc("word_clr", `CMD_SUMMARY_DOUBLE, 2, 16'h0000);
    end
    host.wr(`CMD_VIN_FLOOR, 2, 16'h5555);
    rdc("floor_ro", `CMD_VIN_FLOOR, 2, 16'hF00C);
    rdc("link_ro", `CMD_LINK_FAULTS, 1, 16'h0080);
    host.wr(`CMD_CLEAR_FAULTS, 0, 16'h0000);
    host.wr(`CMD_VIN_ON, 2, 16'hF009);
    repeat (4) @(negedge clk_i);
    check("alert_rej", 16'(alert_oe_o), 16'h1);
    check("pins_lo", 16'({sda_o, alert_o}), 16'h0);
    rdc("sum_rej", `CMD_SUMMARY_OCTET, 1, 16'h0002);
    rdc("link_rej", `CMD_LINK_FAULTS, 1, 16'h0040);
    // Short write: counted as a framing fault and dropped
    host.wr(`CMD_VOUT_OFS_TRIM, 1, 16'h0055);
    rdc("link_len", `CMD_LINK_FAULTS, 1, 16'h0042);
    rdc("ofs_keep", `CMD_VOUT_OFS_TRIM, 2, o[15:0]);
    finish_test();
  end
endmodule
`default_nettype wire
